// ===== src/fcm_pkg.sv
// package: constants and types for fifo clock master and width config
package fcm_pkg;
  // ----------------------------------------
  // width select decode
  // ----------------------------------------
  localparam logic [2:0]  WSEL_X9       = 3'h0;
  localparam logic [2:0]  WSEL_X18      = 3'h3;
  localparam logic [2:0]  WSEL_X36      = 3'h7;
  localparam int          WSEL_W        = 3;
  localparam int          WIDTH_W       = 6;
  localparam int          DEPTH_W       = 24;
  // depth in words, log2: 8M, 4M, 2M
  localparam logic [4:0]  DEPTH_LOG_8M  = 5'h17;
  localparam logic [4:0]  DEPTH_LOG_4M  = 5'h16;
  localparam logic [4:0]  DEPTH_LOG_2M  = 5'h15;
  localparam logic [3:0]  GUARD_MIN     = 4'h4;
  localparam logic [3:0]  GUARD_MAX     = 4'h8;
  localparam logic [3:0]  GUARD_LOCS    = 4'h8;
  // ----------------------------------------
  // configuration register
  // ----------------------------------------
  localparam logic [3:0]  REG_FAST_CLK  = 4'hA;
  localparam int          FAST_BIT_POS  = 7;
  localparam logic [7:0]  FAST_RST      = 8'h80;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int          CNT_W         = 10;
  localparam logic [9:0]  CNT_TERM      = 10'h3FF;
  // pll lock interval, in system clock (clk_i) cycles
  localparam int          PLL_CYCLES    = 1024;
  localparam logic [10:0] PLL_COUNT     = 11'(PLL_CYCLES);
  localparam int          PLL_W         = 11;

  typedef enum logic [1:0] {
    FCM_EVAL = 2'b00,
    FCM_LOCK = 2'b01,
    FCM_RUN  = 2'b11
  } fcm_state_e;

  // word width per select code (bits)
  function automatic logic [5:0] fcm_width(input logic [2:0] sel);
    case (sel)
      3'h0:    fcm_width = 6'd9;
      3'h1:    fcm_width = 6'd12;
      3'h2:    fcm_width = 6'd16;
      3'h3:    fcm_width = 6'd18;
      3'h4:    fcm_width = 6'd20;
      3'h5:    fcm_width = 6'd24;
      3'h6:    fcm_width = 6'd32;
      default: fcm_width = 6'd36;
    endcase
  endfunction : fcm_width

  // log2 of single-queue depth per select code
  function automatic logic [4:0] fcm_depth_log(input logic [2:0] sel);
    if (sel == WSEL_X9) begin
      fcm_depth_log = DEPTH_LOG_8M;
    end else if (sel <= WSEL_X18) begin
      fcm_depth_log = DEPTH_LOG_4M;
    end else begin
      fcm_depth_log = DEPTH_LOG_2M;
    end
  endfunction : fcm_depth_log
endpackage : fcm_pkg

// ===== src/fcm_if.sv
// interface: port clock ticks, reset, width select and config register access
`timescale 1ns/1ps
`default_nettype none
interface fcm_if;
  logic       wclk_tick;       // one-cycle enable per write port clock edge
  logic       rclk_tick;       // one-cycle enable per read port clock edge
  logic       master_reset_pin; // restarts evaluation, active high
  logic [2:0] port_width_select;
  logic       cfg_wr;          // config write strobe
  logic [3:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic [7:0] cfg_rdata;
  logic       pll_locked;      // device ready for fifo traffic
  logic       master_is_wclk;

  modport device (
    input  wclk_tick, rclk_tick, master_reset_pin, port_width_select,
           cfg_wr, cfg_addr, cfg_wdata,
    output cfg_rdata, pll_locked, master_is_wclk
  );
  modport host (
    output wclk_tick, rclk_tick, master_reset_pin, port_width_select,
           cfg_wr, cfg_addr, cfg_wdata,
    input  cfg_rdata, pll_locked, master_is_wclk
  );
endinterface : fcm_if
`default_nettype wire

// ===== src/fcm_device.sv
// device end: width decode, faster-clock evaluation, pll lock timing
`timescale 1ns/1ps
`default_nettype none
module fcm_device (
  input  wire logic         clk_i,         // 10 mhz system clock
  input  wire logic         sys_rst_i,     // sync reset, active high
  fcm_if.device             link,          // port side
  input  wire logic         two_queue_i,   // two-queue mode select
  output logic [5:0]        word_width_o,  // decoded word width, bits
  output logic [4:0]        depth_log_o,   // log2 of queue depth
  output logic [3:0]        guard_locs_o,  // unwritable guard locations
  output logic              eval_done_o    // evaluation finished
);
  typedef struct packed {
    fcm_pkg::fcm_state_e st;
    logic [9:0]          wcnt;
    logic [9:0]          rcnt;
    logic [10:0]         pll;
    logic                fast;
    logic [5:0]          width;
    logic [4:0]          dlog;
    logic [3:0]          guard;
    logic                done;
    logic [7:0]          rdata;
    logic                freq_chg;
  } fcm_dev_s;

  fcm_dev_s s_r;
  fcm_dev_s s_nxt;
  logic     w_term;
  logic     r_term;

  assign w_term = link.wclk_tick && (s_r.wcnt == fcm_pkg::CNT_TERM);
  assign r_term = link.rclk_tick && (s_r.rcnt == fcm_pkg::CNT_TERM);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.width = fcm_pkg::fcm_width(link.port_width_select);
    // second queue takes half the storage
    s_nxt.dlog = fcm_pkg::fcm_depth_log(link.port_width_select)
                 - {4'h0, two_queue_i};
    s_nxt.guard = fcm_pkg::GUARD_LOCS;
    s_nxt.freq_chg = 1'b0;
    case (s_r.st)
      fcm_pkg::FCM_EVAL: begin
        if (link.wclk_tick) begin
          s_nxt.wcnt = s_r.wcnt + 10'h001;
        end
        if (link.rclk_tick) begin
          s_nxt.rcnt = s_r.rcnt + 10'h001;
        end
        if (w_term || r_term) begin
          s_nxt.fast = w_term;
          s_nxt.done = 1'b1;
          s_nxt.st   = fcm_pkg::FCM_LOCK;
          s_nxt.pll  = fcm_pkg::PLL_COUNT;
        end
      end
      fcm_pkg::FCM_LOCK: begin
        if (s_r.pll == 11'h000) begin
          s_nxt.st = fcm_pkg::FCM_RUN;
        end else begin
          s_nxt.pll = s_r.pll - 11'h001;
        end
      end
      fcm_pkg::FCM_RUN: begin
      end
      default: begin
        s_nxt.st = fcm_pkg::FCM_EVAL;
      end
    endcase
    // user write replaces the evaluated master, pll relocks on change
    if (link.cfg_wr && link.cfg_addr == fcm_pkg::REG_FAST_CLK && s_r.done) begin
      s_nxt.fast = link.cfg_wdata[fcm_pkg::FAST_BIT_POS];
      if (link.cfg_wdata[fcm_pkg::FAST_BIT_POS] != s_r.fast) begin
        s_nxt.freq_chg = 1'b1;
        s_nxt.st  = fcm_pkg::FCM_LOCK;
        s_nxt.pll = fcm_pkg::PLL_COUNT;
      end
    end
    if (link.master_reset_pin) begin
      s_nxt.st   = fcm_pkg::FCM_EVAL;
      s_nxt.wcnt = '0;
      s_nxt.rcnt = '0;
      s_nxt.pll  = '0;
      s_nxt.done = 1'b0;
      s_nxt.fast = fcm_pkg::FAST_RST[fcm_pkg::FAST_BIT_POS];
    end
    // read data follows the final fast bit, reset included
    s_nxt.rdata = (link.cfg_addr == fcm_pkg::REG_FAST_CLK)
                  ? {s_nxt.fast, 7'h00} : 8'h00;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_r.st       <= fcm_pkg::FCM_EVAL;
      s_r.wcnt     <= '0;
      s_r.rcnt     <= '0;
      s_r.pll      <= '0;
      s_r.fast     <= fcm_pkg::FAST_RST[fcm_pkg::FAST_BIT_POS];
      s_r.width    <= '0;
      s_r.dlog     <= '0;
      s_r.guard    <= fcm_pkg::GUARD_LOCS;
      s_r.done     <= 1'b0;
      s_r.rdata    <= fcm_pkg::FAST_RST;
      s_r.freq_chg <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.cfg_rdata      = s_r.rdata;
  assign link.pll_locked     = (s_r.st == fcm_pkg::FCM_RUN);
  assign link.master_is_wclk = s_r.fast;
  assign word_width_o        = s_r.width;
  assign depth_log_o         = s_r.dlog;
  assign guard_locs_o        = s_r.guard;
  assign eval_done_o         = s_r.done;
endmodule : fcm_device
`default_nettype wire

// ===== src/fcm_host.sv
// host end: port clock tick generation, reset, config access, traffic gating
`timescale 1ns/1ps
`default_nettype none
module fcm_host (
  input  wire logic       clk_i,        // 10 mhz system clock
  input  wire logic       sys_rst_i,    // sync reset, active high
  fcm_if.host             link,         // device side
  input  wire logic [3:0] wdiv_i,       // write tick divide minus one
  input  wire logic [3:0] rdiv_i,       // read tick divide minus one
  input  wire logic [2:0] width_sel_i,  // port width select
  input  wire logic       mreset_i,     // request master reset pulse
  input  wire logic       cfg_wr_i,     // request config write
  input  wire logic [3:0] cfg_addr_i,   // config address
  input  wire logic [7:0] cfg_wdata_i,  // config write data
  output logic            fifo_ok_o     // reads and writes allowed
);
  typedef struct packed {
    logic [3:0] wdiv_cnt;
    logic [3:0] rdiv_cnt;
    logic       wtick;
    logic       rtick;
    logic       mrst;
    logic [2:0] wsel;
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       ok;
  } fcm_host_s;

  fcm_host_s h_r;
  fcm_host_s h_nxt;
  logic [3:0] wdiv_lim;
  logic [3:0] rdiv_lim;

  // ratio held in 0.5..2 by clamping either divide to at most twice the other plus one
  always_comb begin
    wdiv_lim = wdiv_i;
    rdiv_lim = rdiv_i;
    if ({1'b0, rdiv_i} > ({wdiv_i, 1'b0} + 5'h01)) begin
      rdiv_lim = 4'({wdiv_i, 1'b0} + 5'h01);
    end
    if ({1'b0, wdiv_i} > ({rdiv_i, 1'b0} + 5'h01)) begin
      wdiv_lim = 4'({rdiv_i, 1'b0} + 5'h01);
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    h_nxt = h_r;
    // ticks run free, never gated
    h_nxt.wtick = (h_r.wdiv_cnt == 4'h0);
    h_nxt.rtick = (h_r.rdiv_cnt == 4'h0);
    h_nxt.wdiv_cnt = (h_r.wdiv_cnt == 4'h0) ? wdiv_lim : h_r.wdiv_cnt - 4'h1;
    h_nxt.rdiv_cnt = (h_r.rdiv_cnt == 4'h0) ? rdiv_lim : h_r.rdiv_cnt - 4'h1;
    // dividers restart together so equal rates tie after master reset
    if (mreset_i) begin
      h_nxt.wdiv_cnt = 4'h0;
      h_nxt.rdiv_cnt = 4'h0;
    end
    h_nxt.mrst  = mreset_i;
    h_nxt.wsel  = width_sel_i;
    h_nxt.wr    = cfg_wr_i;
    h_nxt.addr  = cfg_addr_i;
    h_nxt.wdata = cfg_wdata_i;
    // traffic waits for relock after any fast-bit change
    h_nxt.ok = link.pll_locked && !cfg_wr_i && !h_r.wr;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      h_r.wdiv_cnt <= '0;
      h_r.rdiv_cnt <= '0;
      h_r.wtick    <= 1'b0;
      h_r.rtick    <= 1'b0;
      h_r.mrst     <= 1'b1;
      h_r.wsel     <= fcm_pkg::WSEL_X36;
      h_r.wr       <= 1'b0;
      h_r.addr     <= '0;
      h_r.wdata    <= '0;
      h_r.ok       <= 1'b0;
    end else begin
      h_r <= h_nxt;
    end
  end

  assign link.wclk_tick         = h_r.wtick;
  assign link.rclk_tick         = h_r.rtick;
  assign link.master_reset_pin  = h_r.mrst;
  assign link.port_width_select = h_r.wsel;
  assign link.cfg_wr            = h_r.wr;
  assign link.cfg_addr          = h_r.addr;
  assign link.cfg_wdata         = h_r.wdata;
  assign fifo_ok_o              = h_r.ok;
endmodule : fcm_host
`default_nettype wire

// ===== tb/fcm_checker.sv
// checker: clock master choice, lock timing and fast-bit register
`timescale 1ns/1ps
`default_nettype none
module fcm_checker (
  input wire logic       clk_i,            // system clock
  input wire logic       sys_rst_i,        // sync reset
  input wire logic       wclk_tick,        // write tick
  input wire logic       rclk_tick,        // read tick
  input wire logic       master_reset_pin, // master reset
  input wire logic       cfg_wr,           // config write
  input wire logic [3:0] cfg_addr,         // config address
  input wire logic [7:0] cfg_wdata,        // write data
  input wire logic [7:0] cfg_rdata,        // read data
  input wire logic       pll_locked,       // lock status
  input wire logic       master_is_wclk    // fast bit
);
  logic [10:0] low_r, wcnt_r, rcnt_r;
  logic        dec_r, wfst_r, wseen_r;
  logic        hit_w, hit_r, wr_a, go;
  assign hit_w = wclk_tick && wcnt_r == 11'h3ff;
  assign hit_r = rclk_tick && rcnt_r == 11'h3ff;
  assign wr_a  = cfg_wr && cfg_addr == fcm_pkg::REG_FAST_CLK;
  assign go    = wr_a && pll_locked && !master_reset_pin;
  // tick counts since master reset and who got to terminal first
  always_ff @(posedge clk_i) begin
    low_r <= (sys_rst_i || pll_locked) ? 11'h000 : low_r + 11'(!low_r[10]);
    if (sys_rst_i || master_reset_pin) begin
      wcnt_r  <= '0;
      rcnt_r  <= '0;
      dec_r   <= 1'b0;
      wfst_r  <= 1'b0;
      wseen_r <= 1'b0;
    end else begin
      wcnt_r  <= wcnt_r + 11'(wclk_tick && !wcnt_r[10]);
      rcnt_r  <= rcnt_r + 11'(rclk_tick && !rcnt_r[10]);
      wseen_r <= wseen_r || (wr_a && dec_r);
      if (!dec_r && (hit_w || hit_r)) begin
        dec_r  <= 1'b1;
        wfst_r <= hit_w;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_rd_zero;
    !$past(sys_rst_i) && $past(cfg_addr) != fcm_pkg::REG_FAST_CLK |-> cfg_rdata == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("stray read data");
  property p_rd_bit;
    !$past(sys_rst_i) && $past(cfg_addr) == fcm_pkg::REG_FAST_CLK && $stable(master_is_wclk)
      |-> cfg_rdata == {master_is_wclk, 7'h00};
  endproperty
  a_rd_bit: assert property (p_rd_bit) else $error("fast bit read wrong");
  property p_mrst;
    master_reset_pin |=> !pll_locked && master_is_wclk;
  endproperty
  a_mrst: assert property (p_mrst) else $error("master reset not taken");
  property p_lock_wait;
    $rose(pll_locked) |-> low_r >= fcm_pkg::PLL_COUNT;
  endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("lock too early");
  property p_eval_len;
    $rose(pll_locked) |-> wcnt_r[10] || rcnt_r[10];
  endproperty
  a_eval_len: assert property (p_eval_len) else $error("evaluation too short");
  property p_pick;
    $rose(pll_locked) && !wseen_r |-> master_is_wclk == wfst_r;
  endproperty
  a_pick: assert property (p_pick) else $error("wrong master clock");
  property p_wr_diff;
    go && cfg_wdata[7] != master_is_wclk |=> !pll_locked && master_is_wclk == $past(cfg_wdata[7]);
  endproperty
  a_wr_diff: assert property (p_wr_diff) else $error("override not taken");
  property p_wr_same;
    go && cfg_wdata[7] == master_is_wclk |=> pll_locked && $stable(master_is_wclk);
  endproperty
  a_wr_same: assert property (p_wr_same) else $error("relock on same value");
  property p_hold;
    pll_locked && !master_reset_pin && !wr_a |=> pll_locked;
  endproperty
  a_hold: assert property (p_hold) else $error("lock dropped");
  c_tie: cover property (hit_w && hit_r && !dec_r);
  c_rfirst: cover property (hit_r && !hit_w && !dec_r);
  c_over: cover property (go ##1 !pll_locked);
endmodule : fcm_checker
`default_nettype wire

// ===== tb/test_fifo_clock_master_and_width_config.sv
// testbench: both link ends with checker, width decode and master choice
`timescale 1ns/1ps
`default_nettype none
module test_fifo_clock_master_and_width_config;
  logic       clk_i = 1'b0, sys_rst_i = 1'b1, mreset_i = 1'b0, cfg_wr_i = 1'b0;
  logic       two_queue_i = 1'b0, fifo_ok_o, eval_done_o;
  logic [3:0] wdiv_i = 4'h0, rdiv_i = 4'h0, cfg_addr_i = 4'h0, guard_locs_o;
  logic [2:0] width_sel_i = 3'h7;
  logic [7:0] cfg_wdata_i = 8'h00;
  logic [5:0] word_width_o;
  logic [4:0] depth_log_o;
  int         fail_count = 0, samples_checked = 0, seed;
  always #50 clk_i = ~clk_i;
  fcm_if link_if ();
  fcm_device u_fcm_device (.clk_i, .sys_rst_i, .link(link_if), .two_queue_i, .word_width_o,
    .depth_log_o, .guard_locs_o, .eval_done_o);
  fcm_host u_fcm_host (.clk_i, .sys_rst_i, .link(link_if), .wdiv_i, .rdiv_i, .width_sel_i,
    .mreset_i, .cfg_wr_i, .cfg_addr_i, .cfg_wdata_i, .fifo_ok_o);
  fcm_checker u_fcm_checker (.clk_i, .sys_rst_i, .wclk_tick(link_if.wclk_tick),
    .rclk_tick(link_if.rclk_tick), .master_reset_pin(link_if.master_reset_pin),
    .cfg_wr(link_if.cfg_wr), .cfg_addr(link_if.cfg_addr), .cfg_wdata(link_if.cfg_wdata),
    .cfg_rdata(link_if.cfg_rdata), .pll_locked(link_if.pll_locked),
    .master_is_wclk(link_if.master_is_wclk));
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic cfg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cfg_wr_i <= 1'b1;
    cfg_addr_i <= a;
    cfg_wdata_i <= d;
    @(posedge clk_i);
    cfg_wr_i <= 1'b0;
  endtask : cfg_write
  task automatic wait_lock();
    int n;
    n = 0;
    while (link_if.pll_locked !== 1'b1 && n < 6000) begin
      @(negedge clk_i);
      n++;
    end
    chk(n < 6000, "no lock");
  endtask : wait_lock
  function automatic logic [5:0] exp_w(input logic [2:0] s);
    logic [5:0] t [8] = '{6'h09, 6'h0c, 6'h10, 6'h12, 6'h14, 6'h18, 6'h20, 6'h24};
    return t[s];
  endfunction : exp_w
  function automatic logic [4:0] exp_d(input logic [2:0] s, input logic q);
    return (s == 3'h0 ? 5'h17 : (s < 3'h4 ? 5'h16 : 5'h15)) - 5'(q);
  endfunction : exp_d
  task automatic run(input logic [2:0] s, input logic [3:0] wd, input logic [3:0] rd);
    logic e, q;
    e = (wd <= rd);
    q = 1'($random(seed));
    @(posedge clk_i);
    width_sel_i <= s;
    wdiv_i <= wd;
    rdiv_i <= rd;
    two_queue_i <= q;
    mreset_i <= 1'b1;
    @(posedge clk_i);
    mreset_i <= 1'b0;
    cyc(3);
    @(negedge clk_i);
    chk(link_if.pll_locked === 1'b0 && eval_done_o === 1'b0, "reset not seen");
    cfg_write(fcm_pkg::REG_FAST_CLK, {~e, 7'h00});
    wait_lock();
    chk(link_if.master_is_wclk === e && eval_done_o === 1'b1, "master wrong");
    chk(word_width_o === exp_w(s), "width wrong");
    chk(depth_log_o === exp_d(s, q), "depth wrong");
    chk(guard_locs_o >= 4'h4 && guard_locs_o <= 4'h8, "guard wrong");
    @(posedge clk_i);
    cfg_addr_i <= fcm_pkg::REG_FAST_CLK;
    cyc(2);
    @(negedge clk_i);
    chk(link_if.cfg_rdata === {e, 7'h00}, "fast bit read wrong");
  endtask : run
  initial begin
    seed = 32'hcc17_4beb;
    cyc(10);
    sys_rst_i <= 1'b0;
    run(3'h7, 4'h0, 4'h0);
    for (int i = 0; i < 8; i++) begin
      run(3'(i), 4'($random(seed) & 1), 4'($random(seed) & 1));
    end
    run(3'h0, 4'h1, 4'h0);
    cfg_write(fcm_pkg::REG_FAST_CLK, 8'h80);
    cyc(1);
    @(negedge clk_i);
    chk(link_if.master_is_wclk === 1'b1 && link_if.pll_locked === 1'b0, "no override");
    chk(fifo_ok_o === 1'b0, "fifo open in relock");
    wait_lock();
    cyc(2);
    @(negedge clk_i);
    chk(fifo_ok_o === 1'b1, "fifo closed after lock");
    cfg_write(fcm_pkg::REG_FAST_CLK, 8'h80);
    cfg_write(4'h3, 8'h00);
    cyc(3);
    @(negedge clk_i);
    chk(link_if.pll_locked === 1'b1 && link_if.master_is_wclk === 1'b1, "bad relock");
    chk(link_if.cfg_rdata === 8'h00, "unmapped read");
    test_done();
  end
  initial begin
    #(100 * 60000);
    fail_count++;
    test_done();
  end
endmodule : test_fifo_clock_master_and_width_config
`default_nettype wire
